// ===== logic/umc_mode_ctrl.sv
/*
  Device mode control register and the suspend, resume, soft reset,
  interrupt gating, suspend pin, clock and pull-up control behind it.
  Assumes a classic Wishbone master on core_clk_i, asynchronous pins
  for configuration and bus power, and USB engine signals on core_clk_i.
*/
// Notes on behaviour
// (RULE_01) top three bits read back the three configuration pin levels
// (RULE_02) dma clock gate bit at 0 stops dma clock, at 1 supplies it
// (RULE_03) bus power pin level reads back as a status bit
// (RULE_04) keep-alive 1 keeps clocks in suspend; 0 stops oscillator and pll
// (RULE_05) clocks halt about 2 ms after suspend request goes 1 then 0
// (RULE_06) resume request 1 then 0 drives 10 ms upstream resume
// (RULE_07) upstream resume starts 5 ms after resume request returns to 0
// (RULE_08) suspend request 1 then 0 enters suspend
// (RULE_09) software reset request 1 then 0 resets like the reset pin
// (RULE_10) global interrupt enable lets all masked-in sources reach the pin
// (RULE_11) enable low blocks pin; enabling with pending asserts at once
// (RULE_12) pulsed mode gives no pulse for events before enable
// (RULE_13) with wake-on-access a register read wakes the device from suspend
// (RULE_14) host must not write until restarted clock is stable
// (RULE_15) indicator control 0: suspend pin high while suspended only
// (RULE_16) indicator control 1: 1 ms high pulse on waking, otherwise low
// (RULE_17) bus connect bit connects the dp pull-up, clearing disconnects
// (RULE_18) writable bits reset to 0; bus reset clears the action bits only (bus reset here also clears wake-on-access and the dma clock gate bit)
// (RULE_19) suspend interrupt after 3 ms idle unless powered and connected
// (RULE_20) actions fire on the 1 to 0 write, never on setting the bit
`timescale 1ns/1ns
module umc_mode_ctrl #(
  parameter int unsigned HALT_DELAY_CYC = umc_pkg::HALT_DELAY_CYC,
  parameter int unsigned RESUME_DELAY_CYC = umc_pkg::RESUME_DELAY_CYC,
  parameter int unsigned RESUME_DRIVE_CYC = umc_pkg::RESUME_DRIVE_CYC,
  parameter int unsigned WAKE_PULSE_CYC = umc_pkg::WAKE_PULSE_CYC,
  parameter int unsigned IDLE_SUSPEND_CYC = umc_pkg::IDLE_SUSPEND_CYC
) (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [umc_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic mode_select_pin_hi_i,
  input wire logic mode_select_pin_lo_i,
  input wire logic bus_config_pin_i,
  input wire logic bus_power_sense_i,
  input wire logic usb_bus_reset_i,
  input wire logic bus_activity_i,
  input wire logic int_pending_i,
  input wire logic int_event_i,
  input wire logic int_pulse_mode_i,
  output logic int_o,
  output logic suspend_event_o,
  output logic soft_reset_o,
  output logic dma_clock_gate_o,
  output logic osc_pll_enable_o,
  output logic suspend_ind_o,
  output logic resume_drive_o,
  output logic pullup_source_pin_o
);

  localparam int unsigned TW = umc_pkg::TIMER_W;

  logic [7:0] ctl;
  logic dma_clock_gate;
  logic [31:0] next_rdata;
  logic wb_req;
  logic hit;
  logic wr_lo;
  logic wr_hi;
  logic rd_hit;
  logic trig_reset;
  logic trig_susp;
  logic trig_resume;
  logic wake;
  logic [umc_pkg::PIN_N-1:0] pin_raw;
  logic [umc_pkg::PIN_N-1:0] pin_s1;
  logic [umc_pkg::PIN_N-1:0] pin_s2;
  logic [umc_pkg::PIN_N-1:0] pin_s3;
  logic [umc_pkg::PIN_N-1:0] pin_val;
  umc_pkg::umc_susp_t sp_state;
  umc_pkg::umc_resume_t rs_state;
  logic halt_busy;
  logic halt_done;
  logic rs_done;
  logic pulse_busy;
  logic idle_done;
  logic idle_load;
  logic idle_first;
  logic glint_q;

  // pins: three flops, a change counts once stages two and three agree
  assign pin_raw = {mode_select_pin_hi_i, mode_select_pin_lo_i, bus_config_pin_i,
                    bus_power_sense_i};

  for (genvar i = 0; i < umc_pkg::PIN_N; i++)
  begin : g_pin_sync
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
      if (!arst_n_i)
      begin
        pin_s1[i] <= 1'b0;
        pin_s2[i] <= 1'b0;
        pin_s3[i] <= 1'b0;
        pin_val[i] <= 1'b0;
      end
      else if (ce_i)
      begin
        pin_s1[i] <= pin_raw[i];
        pin_s2[i] <= pin_s1[i];
        pin_s3[i] <= pin_s2[i];
        if (pin_s2[i] == pin_s3[i])
          pin_val[i] <= pin_s3[i];
      end
    end
  end

  // wishbone slave, one wait state, unmapped reads return zero
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign hit = (wb_adr_i == umc_pkg::MODE_CTRL_OFS);
  assign wr_lo = wb_req && wb_we_i && hit && wb_sel_i[0];
  assign wr_hi = wb_req && wb_we_i && hit && wb_sel_i[1];
  assign rd_hit = wb_req && !wb_we_i && hit;

  assign trig_reset = wr_lo && ctl[umc_pkg::BIT_SRESET] && !wb_dat_i[umc_pkg::BIT_SRESET]; // [RULE_09] [RULE_20]
  assign trig_susp = wr_lo && ctl[umc_pkg::BIT_SUSP] && !wb_dat_i[umc_pkg::BIT_SUSP]; // [RULE_08] [RULE_20]
  assign trig_resume = wr_lo && ctl[umc_pkg::BIT_RESUME] && !wb_dat_i[umc_pkg::BIT_RESUME]; // [RULE_06] [RULE_20]

  always_comb
  begin
    next_rdata = umc_pkg::RDATA_ZERO;
    if (hit)
    begin
      next_rdata[7:0] = ctl;
      next_rdata[umc_pkg::BIT_DMA] = dma_clock_gate;
      next_rdata[umc_pkg::BIT_VBUS] = pin_val[umc_pkg::PIN_VBUS]; // [RULE_03]
      next_rdata[umc_pkg::BIT_CFG_LO] = pin_val[umc_pkg::PIN_CFG_LO]; // [RULE_01]
      next_rdata[umc_pkg::BIT_CFG_MID] = pin_val[umc_pkg::PIN_CFG_MID]; // [RULE_01]
      next_rdata[umc_pkg::BIT_CFG_HI] = pin_val[umc_pkg::PIN_CFG_HI]; // [RULE_01]
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= umc_pkg::RDATA_ZERO;
    end
    else if (ce_i)
    begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i)
        wb_dat_o <= next_rdata;
    end
  end

  // control register: soft reset, then write, then bus reset clearing
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ctl <= umc_pkg::MODE_CTRL_RST;
      dma_clock_gate <= umc_pkg::RST_DMA_GATE;
    end
    else if (ce_i)
    begin
      if (soft_reset_o)
      begin
        ctl <= umc_pkg::MODE_CTRL_RST; // [RULE_09] [RULE_18]
        dma_clock_gate <= umc_pkg::RST_DMA_GATE; // [RULE_18]
      end
      else if (usb_bus_reset_i)
      begin
        ctl <= (wr_lo ? wb_dat_i[7:0] : ctl) & ~umc_pkg::BUSRST_CLEAR; // [RULE_18]
        dma_clock_gate <= 1'b0; // [RULE_18]
      end
      else
      begin
        if (wr_lo)
          ctl <= wb_dat_i[7:0];
        if (wr_hi)
          dma_clock_gate <= wb_dat_i[umc_pkg::BIT_DMA];
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      soft_reset_o <= 1'b0;
    else if (ce_i)
      soft_reset_o <= trig_reset; // [RULE_09]
  end

  // suspend state, wake on access read, resume or bus activity
  assign wake = (rd_hit && ctl[umc_pkg::BIT_WAKE_ACC]) || trig_resume || bus_activity_i; // [RULE_13]

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      sp_state <= umc_pkg::SP_AWAKE;
    else if (ce_i)
    begin
      if (soft_reset_o)
        sp_state <= umc_pkg::SP_AWAKE;
      else
        case (sp_state)
          umc_pkg::SP_AWAKE:
            if (trig_susp)
              sp_state <= umc_pkg::SP_SUSP; // [RULE_08]
          umc_pkg::SP_SUSP:
            if (wake)
              sp_state <= umc_pkg::SP_AWAKE;
            else if (halt_done && !ctl[umc_pkg::BIT_KEEP])
              sp_state <= umc_pkg::SP_HALT; // [RULE_04] [RULE_05]
          umc_pkg::SP_HALT:
            if (wake)
              sp_state <= umc_pkg::SP_AWAKE; // [RULE_13]
          default:
            sp_state <= umc_pkg::SP_AWAKE;
        endcase
    end
  end

  umc_ms_timer #(.WIDTH(TW)) u_halt_timer (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .load_i(trig_susp && !ctl[umc_pkg::BIT_KEEP]), // [RULE_05]
    .abort_i(soft_reset_o || wake),
    .count_i(TW'(HALT_DELAY_CYC)),
    .busy_o(halt_busy),
    .done_o(halt_done)
  );

  // resume: 5 ms wait, then 10 ms drive
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rs_state <= umc_pkg::RS_IDLE;
    else if (ce_i)
    begin
      if (soft_reset_o)
        rs_state <= umc_pkg::RS_IDLE;
      else
        case (rs_state)
          umc_pkg::RS_IDLE:
            if (trig_resume)
              rs_state <= umc_pkg::RS_WAIT; // [RULE_07]
          umc_pkg::RS_WAIT:
            if (rs_done)
              rs_state <= umc_pkg::RS_DRIVE; // [RULE_06]
          umc_pkg::RS_DRIVE:
            if (rs_done)
              rs_state <= umc_pkg::RS_IDLE;
          default:
            rs_state <= umc_pkg::RS_IDLE;
        endcase
    end
  end

  umc_ms_timer #(.WIDTH(TW)) u_resume_timer (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .load_i((rs_state == umc_pkg::RS_IDLE && trig_resume) ||
            (rs_state == umc_pkg::RS_WAIT && rs_done)),
    .abort_i(soft_reset_o),
    .count_i(rs_state == umc_pkg::RS_IDLE ? TW'(RESUME_DELAY_CYC) : TW'(RESUME_DRIVE_CYC)),
    .busy_o(),
    .done_o(rs_done)
  );

  assign resume_drive_o = (rs_state == umc_pkg::RS_DRIVE); // [RULE_06]

  // suspend indicator pulse on wake
  umc_ms_timer #(.WIDTH(TW)) u_pulse_timer (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .load_i(sp_state != umc_pkg::SP_AWAKE && wake && !soft_reset_o), // [RULE_16]
    .abort_i(soft_reset_o),
    .count_i(TW'(WAKE_PULSE_CYC)),
    .busy_o(pulse_busy),
    .done_o()
  );

  // idle timer for the suspend interrupt
  assign idle_load = bus_activity_i || idle_first ||
                     (pin_val[umc_pkg::PIN_VBUS] && ctl[umc_pkg::BIT_CONNECT]); // [RULE_19]

  umc_ms_timer #(.WIDTH(TW)) u_idle_timer (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .load_i(idle_load),
    .abort_i(soft_reset_o),
    .count_i(TW'(IDLE_SUSPEND_CYC)),
    .busy_o(),
    .done_o(idle_done)
  );

  // outputs from flops
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      idle_first <= 1'b1;
      glint_q <= 1'b0;
      int_o <= 1'b0;
      suspend_event_o <= 1'b0;
      dma_clock_gate_o <= 1'b0;
      osc_pll_enable_o <= 1'b1;
      suspend_ind_o <= 1'b0;
      pullup_source_pin_o <= 1'b0;
    end
    else if (ce_i)
    begin
      idle_first <= 1'b0;
      glint_q <= ctl[umc_pkg::BIT_GLINT];
      if (int_pulse_mode_i)
        int_o <= ctl[umc_pkg::BIT_GLINT] && glint_q && int_event_i; // [RULE_12]
      else
        int_o <= ctl[umc_pkg::BIT_GLINT] && int_pending_i; // [RULE_10] [RULE_11]
      suspend_event_o <= idle_done; // [RULE_19]
      dma_clock_gate_o <= dma_clock_gate; // [RULE_02]
      osc_pll_enable_o <= (sp_state != umc_pkg::SP_HALT); // [RULE_04]
      if (ctl[umc_pkg::BIT_IND_CTL])
        suspend_ind_o <= pulse_busy; // [RULE_16]
      else
        suspend_ind_o <= (sp_state != umc_pkg::SP_AWAKE); // [RULE_15]
      pullup_source_pin_o <= ctl[umc_pkg::BIT_CONNECT]; // [RULE_17]
    end
  end

  default clocking mc_cb @(posedge core_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  a_dma_gate_write: assert property (wr_hi && ce_i && !soft_reset_o && !usb_bus_reset_i ##1 ce_i
    |=> dma_clock_gate_o == $past(wb_dat_i[umc_pkg::BIT_DMA], 2)) // [RULE_02]
    else $error("dma clock gate does not follow written bit");
  a_pullup_write: assert property (wr_lo && ce_i && !soft_reset_o ##1 ce_i
    |=> pullup_source_pin_o == $past(wb_dat_i[umc_pkg::BIT_CONNECT], 2)) // [RULE_17]
    else $error("pull-up does not follow bus connect bit");
  a_busrst_bits: assert property (usb_bus_reset_i && !wr_lo && !soft_reset_o && ce_i
    |=> (ctl & umc_pkg::BUSRST_CLEAR) == 8'h00 && !dma_clock_gate &&
        (ctl & ~umc_pkg::BUSRST_CLEAR) == $past(ctl & ~umc_pkg::BUSRST_CLEAR)) // [RULE_18]
    else $error("bus reset handled wrong bits");
  a_sreset_pulse: assert property (trig_reset && ce_i |=> soft_reset_o) // [RULE_09]
    else $error("soft reset not issued on 1 to 0 write");
  a_set_no_act: assert property (wr_lo && !ctl[umc_pkg::BIT_SRESET] && ce_i
    |=> !soft_reset_o) // [RULE_20]
    else $error("soft reset issued without 1 to 0 write");
  a_susp_entry: assert property (trig_susp && !soft_reset_o && ce_i
    && sp_state == umc_pkg::SP_AWAKE |=> sp_state == umc_pkg::SP_SUSP) // [RULE_08]
    else $error("suspend not entered");
  a_glint_block: assert property (!ctl[umc_pkg::BIT_GLINT] && ce_i |=> !int_o) // [RULE_11]
    else $error("interrupt pin active while globally disabled");
  a_glint_now: assert property (ctl[umc_pkg::BIT_GLINT] && int_pending_i && !int_pulse_mode_i
    && ce_i |=> int_o) // [RULE_10]
    else $error("pending interrupt not shown at once");
  a_pulse_old: assert property (int_pulse_mode_i && !glint_q && ce_i |=> !int_o) // [RULE_12]
    else $error("pulse for event before enable");
  a_ind_level: assert property (!ctl[umc_pkg::BIT_IND_CTL] && ce_i
    |=> suspend_ind_o == ($past(sp_state) != umc_pkg::SP_AWAKE)) // [RULE_15]
    else $error("suspend pin not following suspend state");
  a_resume_wait: assert property (trig_resume && rs_state == umc_pkg::RS_IDLE && !soft_reset_o
    && ce_i |=> rs_state == umc_pkg::RS_WAIT && !resume_drive_o) // [RULE_07]
    else $error("resume did not start its delay");
  a_read_wake: assert property (rd_hit && ctl[umc_pkg::BIT_WAKE_ACC] && ce_i
    && sp_state != umc_pkg::SP_AWAKE |=> sp_state == umc_pkg::SP_AWAKE) // [RULE_13]
    else $error("read did not wake device");
  a_halt_keep: assert property (ctl[umc_pkg::BIT_KEEP] && sp_state != umc_pkg::SP_HALT
    && ce_i |=> sp_state != umc_pkg::SP_HALT) // [RULE_04]
    else $error("clocks halted with keep alive set");
  a_idle_suppr: assert property (pin_val[umc_pkg::PIN_VBUS] && ctl[umc_pkg::BIT_CONNECT]
    && ce_i ##1 ce_i |=> !suspend_event_o) // [RULE_19]
    else $error("suspend interrupt while powered and connected");
  a_ro_bits: assert property (rd_hit && ce_i |=> wb_dat_o[umc_pkg::BIT_CFG_HI] ==
    $past(pin_val[umc_pkg::PIN_CFG_HI]) && wb_dat_o[umc_pkg::BIT_VBUS] ==
    $past(pin_val[umc_pkg::PIN_VBUS])) // [RULE_01] [RULE_03]
    else $error("read-only pin copies wrong");

  c_suspend: cover property (sp_state == umc_pkg::SP_AWAKE ##1 sp_state == umc_pkg::SP_SUSP);
  c_halt: cover property (sp_state == umc_pkg::SP_HALT);
  c_resume: cover property (rs_state == umc_pkg::RS_WAIT ##1 rs_state == umc_pkg::RS_DRIVE);
  c_sreset: cover property (soft_reset_o);

endmodule

// ===== logic/umc_pkg.sv
/*
  Constants for the device mode control block: register map, field
  positions, reset values, state codes and timing counts.
  Assumes a 250 MHz core clock and a 32-bit classic Wishbone bus.
*/
package umc_pkg;

  // clock rate and derived cycles per millisecond
  localparam int unsigned CLK_FREQ_KHZ = 250_000;

  // times in milliseconds
  localparam int unsigned HALT_DELAY_MS = 2;
  localparam int unsigned RESUME_DELAY_MS = 5;
  localparam int unsigned RESUME_DRIVE_MS = 10;
  localparam int unsigned WAKE_PULSE_MS = 1;
  localparam int unsigned IDLE_SUSPEND_MS = 3;

  // cycle counts derived from the times
  localparam int unsigned HALT_DELAY_CYC = HALT_DELAY_MS * CLK_FREQ_KHZ;
  localparam int unsigned RESUME_DELAY_CYC = RESUME_DELAY_MS * CLK_FREQ_KHZ;
  localparam int unsigned RESUME_DRIVE_CYC = RESUME_DRIVE_MS * CLK_FREQ_KHZ;
  localparam int unsigned WAKE_PULSE_CYC = WAKE_PULSE_MS * CLK_FREQ_KHZ;
  localparam int unsigned IDLE_SUSPEND_CYC = IDLE_SUSPEND_MS * CLK_FREQ_KHZ;

  // timer counter width, holds the longest count
  localparam int unsigned TIMER_W = 24;

  // register map
  localparam int unsigned ADR_W = 8;
  localparam logic [7:0] MODE_CTRL_OFS = 8'h0c;
  localparam logic [7:0] MODE_CTRL_RST = 8'h00;
  localparam logic RST_DMA_GATE = 1'b0;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

  // low byte field positions
  localparam int unsigned BIT_CONNECT = 0;
  localparam int unsigned BIT_IND_CTL = 1;
  localparam int unsigned BIT_WAKE_ACC = 2;
  localparam int unsigned BIT_GLINT = 3;
  localparam int unsigned BIT_SRESET = 4;
  localparam int unsigned BIT_SUSP = 5;
  localparam int unsigned BIT_RESUME = 6;
  localparam int unsigned BIT_KEEP = 7;
  // high byte field positions
  localparam int unsigned BIT_VBUS = 8;
  localparam int unsigned BIT_DMA = 9;
  localparam int unsigned BIT_CFG_LO = 13;
  localparam int unsigned BIT_CFG_MID = 14;
  localparam int unsigned BIT_CFG_HI = 15;

  // low byte bits that a usb bus reset clears
  localparam logic [7:0] BUSRST_CLEAR = 8'h74;

  // synchronised pin vector layout
  localparam int unsigned PIN_N = 4;
  localparam int unsigned PIN_VBUS = 0;
  localparam int unsigned PIN_CFG_LO = 1;
  localparam int unsigned PIN_CFG_MID = 2;
  localparam int unsigned PIN_CFG_HI = 3;

  typedef enum logic [2:0] {
    SP_AWAKE = 3'b001,
    SP_SUSP = 3'b010,
    SP_HALT = 3'b100
  } umc_susp_t;

  typedef enum logic [2:0] {
    RS_IDLE = 3'b001,
    RS_WAIT = 3'b010,
    RS_DRIVE = 3'b100
  } umc_resume_t;

endpackage

// ===== logic/umc_ms_timer.sv
/*
  Down-counting delay timer with load, abort and a one-cycle done pulse.
  Assumes one clock, a clock enable and an asynchronous active-low reset.
*/
`timescale 1ns/1ns
module umc_ms_timer #(
  parameter int unsigned WIDTH = 24
) (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic load_i,
  input wire logic abort_i,
  input wire logic [WIDTH-1:0] count_i,
  output logic busy_o,
  output logic done_o
);

  logic [WIDTH-1:0] cnt;

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cnt <= '0;
    end
    else if (ce_i)
    begin
      if (abort_i)
        cnt <= '0;
      else if (load_i)
        cnt <= count_i;
      else if (cnt != '0)
        cnt <= cnt - WIDTH'(1);
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      done_o <= 1'b0;
    else if (ce_i)
      done_o <= !abort_i && !load_i && (cnt == WIDTH'(1));
  end

  assign busy_o = (cnt != '0);

  default clocking tm_cb @(posedge core_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  a_timer_done_end: assert property (ce_i && !abort_i && !load_i && cnt == WIDTH'(1)
    |=> done_o && !busy_o)
    else $error("timer did not finish at the end of its count");

endmodule

// ===== tb/umc_host_model.sv
/*
  Host processor model: classic Wishbone single-cycle master tasks.
  Assumes one shared clock and a slave that acks each request.
*/
`timescale 1ns/1ns
module umc_host_model (
  input wire logic core_clk_i,
  input wire logic ack_i,
  input wire logic [31:0] rdat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  initial
  begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h0000_0000;
  end

  // request held until ack is sampled at an edge
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                      output logic [31:0] q);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= we;
    adr_o <= adr;
    sel_o <= 4'hf;
    dat_o <= dat;
    @(posedge core_clk_i);
    // no cycle limit of its own: the bench watchdog ends a hung wait
    while (ack_i !== 1'b1)
    begin
      @(posedge core_clk_i);
    end
    q = rdat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    dat_o <= ~dat;
    // idle cycle; no write follows a waking read before it
    @(posedge core_clk_i);
  endtask
endmodule

// ===== tb/tb.sv
/*
  Self-checking bench for the device mode control block.
  Assumes shortened timing parameters and the host model as bus master.
*/
`timescale 1ns/1ns
module tb;
  localparam int HALT = 20;
  localparam int RDLY = 30;
  localparam int RDRV = 40;
  localparam int WAKE = 10;
  localparam int IDLE = 25;
  logic clk, arst_n, cyc, stb, we, ack, hi, mid, lo, vbus, brst, act, pend, ev, pmode;
  logic intr, sev, srst, dma, osc, ind, rsm, pu, ce;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q, hdat;
  int failures = 0;
  int total_checks = 0;
  int seed = 32'h6b24;
  int sev_n, srst_n, ind_n, int_n, n;

  umc_host_model i_host (.core_clk_i(clk), .ack_i(ack), .rdat_i(rdat), .cyc_o(cyc),
    .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(hdat));

  umc_mode_ctrl #(.HALT_DELAY_CYC(HALT), .RESUME_DELAY_CYC(RDLY), .RESUME_DRIVE_CYC(RDRV),
    .WAKE_PULSE_CYC(WAKE), .IDLE_SUSPEND_CYC(IDLE)) i_dut (.core_clk_i(clk),
    .arst_n_i(arst_n), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(hdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .mode_select_pin_hi_i(hi), .mode_select_pin_lo_i(mid), .bus_config_pin_i(lo),
    .bus_power_sense_i(vbus), .usb_bus_reset_i(brst), .bus_activity_i(act),
    .int_pending_i(pend), .int_event_i(ev), .int_pulse_mode_i(pmode), .int_o(intr),
    .suspend_event_o(sev), .soft_reset_o(srst), .dma_clock_gate_o(dma),
    .osc_pll_enable_o(osc), .suspend_ind_o(ind), .resume_drive_o(rsm),
    .pullup_source_pin_o(pu));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // counted on the falling edge, away from the edge where counters are cleared
  always @(negedge clk)
  begin
    sev_n += int'(sev === 1'b1);
    srst_n += int'(srst === 1'b1);
    ind_n += int'(ind === 1'b1);
    int_n += int'(intr === 1'b1);
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic wr(input logic [31:0] d);
    i_host.xfer(1'b1, 8'h0c, d, q);
  endtask

  task automatic rd(input logic [7:0] a);
    i_host.xfer(1'b0, a, 32'h0000_0000, q);
  endtask

  task automatic ticks(input int k);
    repeat (k) @(posedge clk);
  endtask

  // one-cycle pulse on activity or event input
  task automatic pulse(input bit is_ev);
    if (is_ev)
      ev <= 1'b1;
    else
      act <= 1'b1;
    @(posedge clk);
    ev <= 1'b0;
    act <= 1'b0;
  endtask

  function automatic logic [31:0] exp_rd(input logic [31:0] w);
    return {16'h0000, hi, mid, lo, 3'b000, w[9], vbus, w[7:0]};
  endfunction

  initial
  begin
    {arst_n, hi, mid, lo, vbus, brst, act, pend, ev, pmode} = '0;
    ce = 1'b1;
    repeat (4) @(posedge clk);
    chk(32'({osc, pu, dma, ind, rsm, intr}), 32'h0000_0020);
    arst_n <= 1'b1;
    @(posedge clk);
    rd(8'h0c);
    chk(q, exp_rd(32'h0000_0000));
    i_host.xfer(1'b1, 8'h10, 32'hffff_ffff, q);
    rd(8'h10);
    chk(q, 32'h0000_0000);
    for (int i = 0; i < 4; i++)
    begin
      {hi, mid, lo, vbus} <= 4'($random(seed));
      pend <= 1'($random(seed));
      wdat = 32'($random(seed)) & 32'h0000_028f;
      wr(wdat);
      ticks(5);
      rd(8'h0c);
      chk(q, exp_rd(wdat));
      chk(32'({pu, dma, intr}), 32'({wdat[0], wdat[9], wdat[3] & pend}));
    end
    wr(32'h0000_028f);
    brst <= 1'b1;
    ticks(1);
    brst <= 1'b0;
    rd(8'h0c);
    chk(q, exp_rd(32'h0000_008b));
    pmode <= 1'b1;
    pend <= 1'b0;
    wr(32'h0000_0000);
    int_n = 0;
    pulse(1'b1);
    ticks(3);
    chk(int_n, 0);
    wr(32'h0000_0008);
    pulse(1'b1);
    ticks(3);
    chk(int_n, 1);
    pmode <= 1'b0;
    wr(32'h0000_0024);
    chk(ind, 1'b0);
    wr(32'h0000_0004);
    chk(ind, 1'b1);
    // clock enable low for 10 edges holds the halt countdown back by 10
    ce <= 1'b0;
    ticks(10);
    ce <= 1'b1;
    ticks(HALT - 8);
    chk(osc, 1'b1);
    ticks(12);
    chk(osc, 1'b0);
    rd(8'h0c);
    ticks(4);
    chk(32'({osc, ind}), 32'h0000_0002);
    wr(32'h0000_00a4);
    wr(32'h0000_0084);
    ticks(HALT + 8);
    chk(osc, 1'b1);
    rd(8'h0c);
    ticks(4);
    wr(32'h0000_0026);
    wr(32'h0000_0006);
    chk(ind, 1'b0);
    ind_n = 0;
    rd(8'h0c);
    ticks(WAKE + 6);
    chk(32'(ind_n >= WAKE && ind_n <= WAKE + 2 && ind === 1'b0), 1);
    wr(32'h0000_0040);
    ticks(RDLY + 4);
    chk(rsm, 1'b0);
    wr(32'h0000_0000);
    for (n = 0; rsm !== 1'b1 && n < 200; n++) @(posedge clk);
    chk(32'(n >= RDLY - 4 && n <= RDLY + 2), 1);
    for (n = 0; rsm === 1'b1 && n < 200; n++) @(posedge clk);
    chk(32'(n >= RDRV && n <= RDRV + 2), 1);
    vbus <= 1'b0;
    pulse(1'b0);
    sev_n = 0;
    ticks(IDLE + 6);
    chk(sev_n, 1);
    vbus <= 1'b1;
    wr(32'h0000_0001);
    ticks(5);
    pulse(1'b0);
    sev_n = 0;
    ticks(IDLE + 10);
    chk(sev_n, 0);
    wr(32'h0000_0219);
    srst_n = 0;
    wr(32'h0000_0209);
    ticks(2);
    chk(srst_n, 1);
    rd(8'h0c);
    chk(q, exp_rd(32'h0000_0000));
    chk(32'({pu, dma}), 32'h0000_0000);
    print_verdict();
  end

  initial
  begin
    #40_000;
    failures++;
    print_verdict();
  end
endmodule
